// [shared/cco_defs.svh]
// register offsets, codes and reset values of the capture/compare block
`ifndef CCO_DEFS_SVH
`define CCO_DEFS_SVH

// ==========================================================
// register byte offsets
`define CCO_OFF_CTL0 8'h00
`define CCO_OFF_CTL1 8'h04
`define CCO_OFF_CTL2 8'h08
`define CCO_OFF_VAL0 8'h10
`define CCO_OFF_VAL1 8'h14
`define CCO_OFF_VAL2 8'h18
`define CCO_OFF_VEC 8'h20
`define CCO_OFF_OVF 8'h24

// ==========================================================
// overflow register bit positions
`define CCO_B_OVF_FLAG 0
`define CCO_B_OVF_IE 1

// ==========================================================
// vector-number codes
`define CCO_VEC_NONE 4'h0
`define CCO_VEC_CH1 4'h2
`define CCO_VEC_CH2 4'h4
`define CCO_VEC_OVF 4'ha

// ==========================================================
// reset values
`define CCO_RST_VAL 16'h0000
`define CCO_RST_CTL 16'h0000

`endif

// [shared/cco_pkg.sv]
// types shared by the capture/compare block
package cco_pkg;

    // ======================================================
    // selectors
    typedef enum logic [1:0] {
        SRC_A = 2'h0,
        SRC_B = 2'h1,
        SRC_GND = 2'h2,
        SRC_VCC = 2'h3
    } cco_src_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } cco_edge_t;

    typedef enum logic [2:0] {
        OM_OUT = 3'h0,
        OM_SET = 3'h1,
        OM_TOG_RST = 3'h2,
        OM_SET_RST = 3'h3,
        OM_TOG = 3'h4,
        OM_RST = 3'h5,
        OM_TOG_SET = 3'h6,
        OM_RST_SET = 3'h7
    } cco_outmode_t;

    // ======================================================
    // capture front end setup
    typedef struct packed {
        cco_edge_t edge_select_field;
        cco_src_t input_source_field;
        logic sync_trigger_bit;
    } cco_capcfg_t;

    // software written channel setup
    typedef struct packed {
        cco_capcfg_t cap;
        logic channel_kind_select;
        cco_outmode_t output_mode_field;
        logic channel_irq_enable;
        logic output_value;
    } cco_cfg_t;

    // channel control word as seen on the bus
    typedef struct packed {
        cco_edge_t edge_select_field;
        cco_src_t input_source_field;
        logic sync_trigger_bit;
        logic latched_input_bit;
        logic reserved;
        logic channel_kind_select;
        cco_outmode_t output_mode_field;
        logic channel_irq_enable;
        logic input_level_bit;
        logic output_value;
        logic overrun_flag;
        logic channel_flag;
    } cco_ctl_t;

endpackage : cco_pkg

// [rtl/cco_cap_input.sv]
// capture input front end: source select, edge detect, optional sync
`timescale 1ns/1ps

module cco_cap_input (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // capture sources
    input wire logic source_input_a,
    input wire logic source_input_b,
    // setup
    input wire cco_pkg::cco_capcfg_t cfg,
    // results
    output logic level,
    output logic capture
);

    // ======================================================
    // source select
    logic sel_now;
    logic lvl_ff;
    logic cap_ff;
    logic cap_sync_ff;
    logic rise;
    logic fall;
    logic edge_hit;

    always_comb begin
        case (cfg.input_source_field)
            cco_pkg::SRC_A: sel_now = source_input_a;
            cco_pkg::SRC_B: sel_now = source_input_b;
            cco_pkg::SRC_GND: sel_now = 1'b0;
            cco_pkg::SRC_VCC: sel_now = 1'b1;
            default: sel_now = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_ff <= 1'b0;
        end else begin
            lvl_ff <= sel_now;
        end
    end

    // ======================================================
    // edge detect
    assign rise = sel_now & ~lvl_ff;
    assign fall = ~sel_now & lvl_ff;

    always_comb begin
        case (cfg.edge_select_field)
            cco_pkg::EDGE_RISE: edge_hit = rise;
            cco_pkg::EDGE_FALL: edge_hit = fall;
            cco_pkg::EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cap_ff <= 1'b0;
            cap_sync_ff <= 1'b0;
        end else begin
            cap_ff <= edge_hit;
            cap_sync_ff <= cap_ff;
        end
    end

    // sync costs one timer clock but keeps the capture off the edge
    assign capture = cfg.sync_trigger_bit ? cap_sync_ff : cap_ff;
    assign level = lvl_ff;

endmodule : cco_cap_input

// [rtl/cco_capture_compare.sv]
// capture/compare channels, output units and interrupt steering
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cco_defs.svh"

module cco_capture_compare #(
    parameter int TW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer counter
    input wire logic [TW-1:0] timer_count,
    input wire logic count_tick,
    input wire logic timer_clear,
    input wire logic overflow_event,
    // capture sources
    input wire logic [2:0] source_input_a,
    input wire logic [2:0] source_input_b,
    // interrupt handshake
    input wire logic global_irq_enable,
    input wire logic irq0_ack,
    output logic irq0_req,
    output logic irq_vec_req,
    // pins
    output logic [2:0] channel_output
);

    localparam int NCH = 3;

    // elaboration check: the count compare serves 2 to 16 bits only
    if (TW < 2 || TW > 16) begin : g_bad_tw
        $error("cco_capture_compare: TW must be 2..16");
    end

    localparam logic [7:0] CTL_OFF [NCH] = '{
        `CCO_OFF_CTL0, `CCO_OFF_CTL1, `CCO_OFF_CTL2};
    localparam logic [7:0] VAL_OFF [NCH] = '{
        `CCO_OFF_VAL0, `CCO_OFF_VAL1, `CCO_OFF_VAL2};

    // ======================================================
    // apb handshake
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [3:0] vec_ff;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit_vec;
    logic hit_ovf;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready_ff;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign hit_vec = (paddr == `CCO_OFF_VEC);
    assign hit_ovf = (paddr == `CCO_OFF_OVF);

    // ======================================================
    // channel state
    cco_pkg::cco_cfg_t cfg_ff [NCH];
    cco_pkg::cco_ctl_t ctl_rb [NCH];
    logic [TW-1:0] val_ff [NCH];
    logic [NCH-1:0] flag_ff;
    logic [NCH-1:0] ovr_ff;
    logic [NCH-1:0] latched_input_bit_ff;
    logic [NCH-1:0] unread_ff;
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] cap_p;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] match;
    logic [NCH-1:0] wr_ctl;
    logic [NCH-1:0] wr_val;
    logic [NCH-1:0] rd_val;
    logic [NCH-1:0] vec_clr;
    logic ovf_flag_ff;
    logic ovf_ie_ff;
    logic ovf_clr;
    logic irq0_ff;
    logic irqv_ff;
    logic [3:0] vec_code;
    cco_pkg::cco_ctl_t wctl;

    assign wctl = cco_pkg::cco_ctl_t'(pwdata[15:0]);

    // ======================================================
    // per channel datapath
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic period_hit;
        logic nxt_out;
        logic nxt_flag;

        assign wr_ctl[i] = wr & (paddr == CTL_OFF[i]);
        assign wr_val[i] = wr & (paddr == VAL_OFF[i]);
        assign rd_val[i] = rd & (paddr == VAL_OFF[i]);
        assign cap_ev[i] = cfg_ff[i].channel_kind_select & cap_p[i];
        assign match[i] = ~cfg_ff[i].channel_kind_select & count_tick
            & (timer_count == val_ff[i]);
        assign period_hit = match[0];

        cco_cap_input u_cap (
            .clk(clk),
            .rst(rst),
            .source_input_a(source_input_a[i]),
            .source_input_b(source_input_b[i]),
            .cfg(cfg_ff[i].cap),
            .level(lvl[i]),
            .capture(cap_p[i])
        );

        // setup register
        always_ff @(posedge clk) begin
            if (rst) begin
                cfg_ff[i] <= cco_pkg::cco_cfg_t'(0);
            end else if (wr_ctl[i]) begin
                cfg_ff[i].cap.edge_select_field <= wctl.edge_select_field;
                cfg_ff[i].cap.input_source_field <= wctl.input_source_field;
                cfg_ff[i].cap.sync_trigger_bit <= wctl.sync_trigger_bit;
                cfg_ff[i].channel_kind_select <= wctl.channel_kind_select;
                cfg_ff[i].output_mode_field <= wctl.output_mode_field;
                cfg_ff[i].channel_irq_enable <= wctl.channel_irq_enable;
                cfg_ff[i].output_value <= wctl.output_value;
            end
        end

        // value register, no shadow copy
        always_ff @(posedge clk) begin
            if (rst) begin
                val_ff[i] <= TW'(`CCO_RST_VAL);
            end else if (cap_ev[i]) begin
                val_ff[i] <= timer_count;
            end else if (wr_val[i]) begin
                val_ff[i] <= pwdata[TW-1:0];
            end
        end

        // channel flag: hardware set wins over any clear
        always_comb begin
            nxt_flag = flag_ff[i];
            if (wr_ctl[i]) begin
                nxt_flag = wctl.channel_flag;
            end
            if (vec_clr[i] || (i == 0 && irq0_ack)) begin
                nxt_flag = 1'b0;
            end
            if (cap_ev[i] || match[i]) begin
                nxt_flag = 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                flag_ff[i] <= 1'b0;
            end else begin
                flag_ff[i] <= nxt_flag;
            end
        end

        // overrun tracking
        always_ff @(posedge clk) begin
            if (rst) begin
                unread_ff[i] <= 1'b0;
            end else if (cap_ev[i]) begin
                unread_ff[i] <= 1'b1;
            end else if (rd_val[i]) begin
                unread_ff[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                ovr_ff[i] <= 1'b0;
            end else if (cap_ev[i] && unread_ff[i] && !rd_val[i]) begin
                ovr_ff[i] <= 1'b1;
            end else if (wr_ctl[i]) begin
                ovr_ff[i] <= wctl.overrun_flag;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                latched_input_bit_ff[i] <= 1'b0;
            end else if (match[i]) begin
                latched_input_bit_ff[i] <= lvl[i];
            end
        end

        // output unit
        always_comb begin
            nxt_out = out_ff[i];
            case (cfg_ff[i].output_mode_field)
                cco_pkg::OM_OUT: nxt_out = cfg_ff[i].output_value;
                cco_pkg::OM_SET: begin
                    if (match[i]) begin
                        nxt_out = 1'b1;
                    end else if (timer_clear) begin
                        nxt_out = 1'b0;
                    end
                end
                cco_pkg::OM_TOG_RST: begin
                    if (match[i]) nxt_out = ~out_ff[i];
                    if (period_hit) nxt_out = 1'b0;
                end
                cco_pkg::OM_SET_RST: begin
                    if (match[i]) nxt_out = 1'b1;
                    if (period_hit) nxt_out = 1'b0;
                end
                cco_pkg::OM_TOG: begin
                    if (match[i]) nxt_out = ~out_ff[i];
                end
                cco_pkg::OM_RST: begin
                    if (match[i]) nxt_out = 1'b0;
                end
                cco_pkg::OM_TOG_SET: begin
                    if (match[i]) nxt_out = ~out_ff[i];
                    if (period_hit) nxt_out = 1'b1;
                end
                cco_pkg::OM_RST_SET: begin
                    if (match[i]) nxt_out = 1'b0;
                    if (period_hit) nxt_out = 1'b1;
                end
                default: nxt_out = out_ff[i];
            endcase
        end

        // mode 0 bypasses the stored bit so the pin moves at the write
        always_ff @(posedge clk) begin
            if (rst) begin
                out_ff[i] <= 1'b0;
            end else if (wr_ctl[i] &&
                         wctl.output_mode_field == cco_pkg::OM_OUT) begin
                out_ff[i] <= wctl.output_value;
            end else begin
                out_ff[i] <= nxt_out;
            end
        end

        // bus view of the control word
        always_comb begin
            ctl_rb[i] = cco_pkg::cco_ctl_t'(`CCO_RST_CTL);
            ctl_rb[i].edge_select_field = cfg_ff[i].cap.edge_select_field;
            ctl_rb[i].input_source_field = cfg_ff[i].cap.input_source_field;
            ctl_rb[i].sync_trigger_bit = cfg_ff[i].cap.sync_trigger_bit;
            ctl_rb[i].latched_input_bit = latched_input_bit_ff[i];
            ctl_rb[i].channel_kind_select = cfg_ff[i].channel_kind_select;
            ctl_rb[i].output_mode_field = cfg_ff[i].output_mode_field;
            ctl_rb[i].channel_irq_enable = cfg_ff[i].channel_irq_enable;
            ctl_rb[i].input_level_bit = lvl[i];
            ctl_rb[i].output_value = cfg_ff[i].output_value;
            ctl_rb[i].overrun_flag = ovr_ff[i];
            ctl_rb[i].channel_flag = flag_ff[i];
        end
    end

    // ======================================================
    // timer overflow flag
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_ie_ff <= 1'b0;
        end else if (wr && hit_ovf) begin
            ovf_ie_ff <= pwdata[`CCO_B_OVF_IE];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_flag_ff <= 1'b0;
        end else if (overflow_event) begin
            ovf_flag_ff <= 1'b1;
        end else if (ovf_clr) begin
            ovf_flag_ff <= 1'b0;
        end else if (wr && hit_ovf) begin
            ovf_flag_ff <= pwdata[`CCO_B_OVF_FLAG];
        end
    end

    // ======================================================
    // vector-number generator
    always_comb begin
        if (flag_ff[1] && cfg_ff[1].channel_irq_enable) begin
            vec_code = `CCO_VEC_CH1;
        end else if (flag_ff[2] && cfg_ff[2].channel_irq_enable) begin
            vec_code = `CCO_VEC_CH2;
        end else if (ovf_flag_ff && ovf_ie_ff) begin
            vec_code = `CCO_VEC_OVF;
        end else begin
            vec_code = `CCO_VEC_NONE;
        end
    end

    // code latched in setup is the one cleared, so read and clear agree
    assign vec_clr[0] = 1'b0;
    assign vec_clr[1] = access & hit_vec & (vec_ff == `CCO_VEC_CH1);
    assign vec_clr[2] = access & hit_vec & (vec_ff == `CCO_VEC_CH2);
    assign ovf_clr = access & hit_vec & (vec_ff == `CCO_VEC_OVF);

    always_ff @(posedge clk) begin
        if (rst) begin
            vec_ff <= `CCO_VEC_NONE;
        end else if (setup && hit_vec) begin
            vec_ff <= vec_code;
        end
    end

    // ======================================================
    // interrupt requests
    always_ff @(posedge clk) begin
        if (rst) begin
            irq0_ff <= 1'b0;
            irqv_ff <= 1'b0;
        end else begin
            irq0_ff <= global_irq_enable & flag_ff[0]
                & cfg_ff[0].channel_irq_enable;
            irqv_ff <= global_irq_enable
                & (vec_code != `CCO_VEC_NONE);
        end
    end

    // ======================================================
    // apb read mux and answer
    logic [31:0] rd_mux;
    logic rd_err;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
        for (int k = 0; k < NCH; k++) begin
            if (paddr == CTL_OFF[k]) begin
                rd_mux = {16'h0000, ctl_rb[k]};
                rd_err = 1'b0;
            end
            if (paddr == VAL_OFF[k]) begin
                rd_mux = 32'(val_ff[k]);
                rd_err = 1'b0;
            end
        end
        if (hit_vec) begin
            rd_mux = {28'h000_0000, vec_code};
            rd_err = 1'b0;
        end
        if (hit_ovf) begin
            rd_mux = {30'h0000_0000, ovf_ie_ff, ovf_flag_ff};
            rd_err = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                pslverr_ff <= rd_err;
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ======================================================
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq0_req = irq0_ff;
    assign irq_vec_req = irqv_ff;
    assign channel_output = out_ff;

endmodule : cco_capture_compare

// [test/cco_capture_compare_props.sv]
// checker watching the capture/compare block ports
`timescale 1ns/1ps
module cco_capture_compare_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // timer and interrupts
    input wire logic count_tick,
    input wire logic timer_clear,
    input wire logic global_irq_enable,
    input wire logic irq0_ack,
    input wire logic irq0_req,
    input wire logic irq_vec_req,
    // pins
    input wire logic [2:0] channel_output
);
    // ==========
    // helpers
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic evt;
    // any cause that may legally move a pin
    assign evt = count_tick || timer_clear || (psel && penable && pwrite);
    // ==========
    // assertions
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        rst |=> channel_output == 3'h0 && !irq0_req && !irq_vec_req)
        else $error("outputs not cleared by reset");
    AST_PIN_NEEDS_CAUSE: assert property (
        $changed(channel_output) |-> $past(evt))
        else $error("pin moved without a cause");
    AST_NO_TICK_STABLE: assert property (
        !evt |=> $stable(channel_output))
        else $error("pin moved without a count");
    AST_IRQ0_GATED: assert property (
        !global_irq_enable [*2] |-> !irq0_req)
        else $error("channel 0 request without global enable");
    AST_VEC_GATED: assert property (
        !global_irq_enable [*2] |-> !irq_vec_req)
        else $error("vector request without global enable");
    AST_ACK_CLEARS: assert property (
        irq0_ack && !count_tick |-> ##[1:2] !irq0_req)
        else $error("channel 0 request stays after service");
    AST_VEC_CODES: assert property (
        pready && !pwrite && paddr == 8'h20 |->
        prdata inside {32'h0, 32'h2, 32'h4, 32'ha})
        else $error("bad vector code");
    AST_ONE_ACCESS: assert property (
        psel && !penable |=> pready)
        else $error("access not answered at once");
    AST_READY_IN_ACCESS: assert property (
        pready |-> psel && penable)
        else $error("ready outside access");
    cover property (psel && penable && paddr == 8'h20);
    cover property (irq0_ack);
    cover property (count_tick ##1 $changed(channel_output));
endmodule : cco_capture_compare_props

bind cco_capture_compare cco_capture_compare_props u_cco_capture_compare_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready),
    .count_tick(count_tick), .timer_clear(timer_clear),
    .global_irq_enable(global_irq_enable), .irq0_ack(irq0_ack),
    .irq0_req(irq0_req), .irq_vec_req(irq_vec_req),
    .channel_output(channel_output)
);

// [test/cco_pin_model.sv]
// pin model: capture sources of the three channels
`timescale 1ns/1ps
module cco_pin_model (
    // clock
    input wire logic clk,
    // capture sources
    output logic [2:0] src_a,
    output logic [2:0] src_b
);
    // ==========
    // drive
    initial begin
        src_a = 3'h0;
        src_b = 3'h7;
    end
    // b is kept inverse of a so a wrong source pick shows
    task automatic set_level(input int ch, input logic v);
        src_a[ch] <= v;
        src_b[ch] <= ~v;
    endtask : set_level
endmodule : cco_pin_model

// [test/test_capture_compare_output_irq.sv]
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "cco_defs.svh"
module test_capture_compare_output_irq;
    // ==========
    // signals
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic count_tick, timer_clear, overflow_event;
    logic global_irq_enable, irq0_ack, irq0_req, irq_vec_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    logic [15:0] timer_count;
    logic [2:0] src_a, src_b, channel_output;
    int mismatches = 0;
    int samples_checked = 0;
    cco_capture_compare u_cco_capture_compare (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
        .count_tick(count_tick), .timer_clear(timer_clear),
        .overflow_event(overflow_event), .source_input_a(src_a),
        .source_input_b(src_b), .global_irq_enable(global_irq_enable),
        .irq0_ack(irq0_ack), .irq0_req(irq0_req),
        .irq_vec_req(irq_vec_req), .channel_output(channel_output));
    cco_pin_model u_cco_pin_model (.clk(clk), .src_a(src_a), .src_b(src_b));
    // ==========
    // common tasks
    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // one word per transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic tick(input logic [15:0] v);
        timer_count <= v;
        count_tick <= 1'b1;
        step(1);
        count_tick <= 1'b0;
        step(1);
    endtask : tick
    // ==========
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < 40; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
            check(32'(err), 32'(a % 16 == 12));
        end
        check(32'(channel_output), 32'h0);
    endtask : t_reset
    task automatic t_compare;
        logic [2:0] m;
        logic s, e;
        apb(1'b1, `CCO_OFF_VAL0, 32'h0009);
        apb(1'b1, `CCO_OFF_VAL1, 32'h0005);
        for (int k = 1; k < 8; k++) begin
            m = 3'(k);
            s = m[0];
            apb(1'b1, `CCO_OFF_CTL1, {29'h0, s, 2'h0});
            check(32'(channel_output[1]), 32'(s));
            apb(1'b1, `CCO_OFF_CTL1, 32'h00e0);
            apb(1'b1, `CCO_OFF_CTL1, {24'h0, m, 5'h0});
            timer_count <= 16'h0005;
            step(2);
            check(32'(channel_output[1]), 32'(s));
            tick(16'h0005);
            e = (m == 3'h1 || m == 3'h3) ? 1'b1 : (m[0] ? 1'b0 : ~s);
            check(32'(channel_output[1]), 32'(e));
            apb(1'b0, `CCO_OFF_CTL1, 32'h0);
            check(32'(rd[0]), 32'h1);
            tick(16'h0009);
            if (m == 3'h2 || m == 3'h3) e = 1'b0;
            if (m > 3'h5) e = 1'b1;
            check(32'(channel_output[1]), 32'(e));
            tick(16'h0005);
            if (m == 3'h4) check(32'(channel_output[1]), 32'(s));
            timer_clear <= 1'b1;
            step(1);
            timer_clear <= 1'b0;
            step(1);
            if (m == 3'h1) check(32'(channel_output[1]), 32'h0);
        end
    endtask : t_compare
    task automatic t_capture;
        logic [31:0] c;
        for (int e = 1; e < 4; e++) begin
            c = 32'(e << 14) | 32'h0100;
            timer_count <= 16'h1230 + 16'(e);
            apb(1'b1, `CCO_OFF_CTL2, c);
            u_cco_pin_model.set_level(2, 1'b1);
            step(4);
            apb(1'b0, `CCO_OFF_CTL2, 32'h0);
            check(32'(rd[3]), 32'h1);
            check(32'(rd[0]), 32'(e % 2));
            apb(1'b0, `CCO_OFF_VAL2, 32'h0);
            check(rd, e == 2 ? 32'h1231 : 32'h1230 + 32'(e));
            apb(1'b1, `CCO_OFF_CTL2, c);
            u_cco_pin_model.set_level(2, 1'b0);
            step(4);
            apb(1'b0, `CCO_OFF_CTL2, 32'h0);
            check(32'(rd[0]), 32'(e / 2));
        end
        timer_count <= 16'h0777;
        apb(1'b1, `CCO_OFF_CTL2, 32'he900);
        apb(1'b0, `CCO_OFF_VAL2, 32'h0);
        apb(1'b1, `CCO_OFF_CTL2, 32'hf900);
        step(4);
        apb(1'b0, `CCO_OFF_CTL2, 32'h0);
        check(32'(rd[1:0]), 32'h1);
        apb(1'b1, `CCO_OFF_CTL2, 32'he900);
        step(4);
        apb(1'b0, `CCO_OFF_CTL2, 32'h0);
        check(32'(rd[1:0]), 32'h3);
        apb(1'b0, `CCO_OFF_VAL2, 32'h0);
        check(rd, 32'h0777);
        apb(1'b0, `CCO_OFF_CTL2, 32'h0);
        check(32'(rd[1]), 32'h1);
        apb(1'b1, `CCO_OFF_CTL2, 32'h1100);
        step(2);
        apb(1'b0, `CCO_OFF_CTL2, 32'h0);
        check(32'(rd[3]), 32'h1);
    endtask : t_capture
    task automatic t_irq;
        apb(1'b1, `CCO_OFF_CTL1, 32'h0011);
        apb(1'b1, `CCO_OFF_CTL2, 32'h0001);
        apb(1'b1, `CCO_OFF_OVF, 32'h0002);
        overflow_event <= 1'b1;
        step(1);
        overflow_event <= 1'b0;
        step(2);
        check(32'(irq_vec_req), 32'h0);
        apb(1'b0, `CCO_OFF_VEC, 32'h0);
        check(rd, 32'h2);
        apb(1'b0, `CCO_OFF_VEC, 32'h0);
        check(rd, 32'ha);
        apb(1'b1, `CCO_OFF_CTL2, 32'h0011);
        global_irq_enable <= 1'b1;
        step(2);
        check(32'(irq_vec_req), 32'h1);
        apb(1'b0, `CCO_OFF_VEC, 32'h0);
        check(rd, 32'h4);
        apb(1'b1, `CCO_OFF_CTL1, 32'h0011);
        apb(1'b1, `CCO_OFF_VEC, 32'h0);
        apb(1'b0, `CCO_OFF_VEC, 32'h0);
        check(rd, 32'h0);
        check(32'(irq_vec_req), 32'h0);
        apb(1'b1, `CCO_OFF_CTL0, 32'h0011);
        step(2);
        check(32'(irq0_req), 32'h1);
        irq0_ack <= 1'b1;
        step(1);
        irq0_ack <= 1'b0;
        step(2);
        check(32'(irq0_req), 32'h0);
        apb(1'b0, `CCO_OFF_CTL0, 32'h0);
        check(32'(rd[0]), 32'h0);
    endtask : t_irq
    // ==========
    // main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, psel, penable, pwrite, count_tick, timer_clear} = 6'h20;
        {overflow_event, global_irq_enable, irq0_ack} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_count = 16'h0000;
        step(12);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_compare();
        t_capture();
        t_irq();
        finish_test();
    end
endmodule : test_capture_compare_output_irq
